// >>> sccs_regs.svh
`ifndef SCCS_REGS_SVH
`define SCCS_REGS_SVH

// ==========================================================
// Register word offsets (byte address = offset times 4)
`define SCCS_OFS_MODE    6'h00
`define SCCS_OFS_CTRL    6'h01
`define SCCS_OFS_STATUS  6'h02
`define SCCS_OFS_TXDATA  6'h03
`define SCCS_OFS_CARD    6'h04
`define SCCS_OFS_IRQ_ST  6'h05
`define SCCS_OFS_IRQ_MSK 6'h06

// ==========================================================
// Mode register fields
`define SCCS_CKS_HI 1
`define SCCS_CKS_LO 0

// Control register fields
`define SCCS_TIE 7
`define SCCS_RIE 6
`define SCCS_TE  5
`define SCCS_RE  4

// Status register fields
`define SCCS_TX_EMPTY_FLAG 4
`define SCCS_RX_FULL_FLAG 3
`define SCCS_OVERRUN_ERROR_FLAG 2
`define SCCS_FER  1
`define SCCS_PER  0

// Card mode register field
`define SCCS_SMART_CARD_SELECT 0

// Interrupt status and mask fields
`define SCCS_EV_TX  0
`define SCCS_EV_RX  1
`define SCCS_EV_ERR 2

// ==========================================================
// Reset values
`define SCCS_RST_BYTE   8'h00
`define SCCS_RST_STATUS 5'h10
`define SCCS_RST_EV     3'h0

// Prescaler masks: phi, phi/4, phi/16, phi/64
`define SCCS_DIV_MASK_0 6'h00
`define SCCS_DIV_MASK_1 6'h03
`define SCCS_DIV_MASK_2 6'h0f
`define SCCS_DIV_MASK_3 6'h3f

`endif

// >>> sccs_pkg.sv
package sccs_pkg;

  // ========================================================
  // Receiver events, one-cycle pulses
  typedef struct packed {
    logic done;
    logic overrun;
    logic framing;
    logic parity;
  } sccs_rx_ev_t;

  // Interrupt request lines toward the controller
  typedef struct packed {
    logic err;
    logic rx;
    logic tx;
  } sccs_irq_req_t;

  // Whole state of the control slice
  typedef struct packed {
    logic [7:0]    mode;
    logic [7:0]    ctrl;
    logic [4:0]    status;
    logic [4:0]    seen;
    logic [7:0]    txdata;
    logic          card;
    logic [2:0]    ev;
    logic [2:0]    mask;
    logic          ack;
    logic [7:0]    rdata;
    sccs_irq_req_t req;
    logic          irq;
    logic [5:0]    div_cnt;
    logic          baud_en;
    logic          tx_go;
    logic [1:0]    low_normal;
    logic [1:0]    low_card;
  } sccs_state_t;

endpackage

// >>> sccs_ctrl.sv
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`include "sccs_regs.svh"
// What this block does
// RULE_01: The clock select code 00/01/10/11 feeds phi, phi/4, phi/16 or phi/64 to the baud generator.
// RULE_02: The prescaler exponent reported for the bit rate is the decimal value of the select code.
// RULE_03: Some control bits change meaning between normal serial mode and smart card mode.
// RULE_04: Transmit interrupt enable, control bit 7 reset 0, lets the transmit-empty request out.
// RULE_05: The transmit request drops when the empty flag is read as 1 then written 0, or when its enable clears.
// RULE_06: Receive interrupt enable, control bit 6 reset 0, lets both receive-full and error requests out.
// RULE_07: Receive and error requests drop after a flag is read as 1 and cleared, or when the enable clears.
// RULE_08: With transmit enabled, a frame starts once data is written and the empty flag is cleared.
// RULE_09: While transmit enable is 0 the transmitter is off and the empty flag is held at 1.
// RULE_10: Receive enable 1 accepts incoming frames; 0 disables the receiver.
// RULE_11: Smart card behaviour applies when the card select bit is 1, normal serial when it is 0.
// RULE_12: Each request is the AND of its flags and its enable, so it drops as soon as either clears.
module sccs_ctrl (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   tx_taken,
  input  wire sccs_pkg::sccs_rx_ev_t  rx_ev,
  output logic                        tx_go,
  output logic      [7:0]             tx_data,
  output logic                        tx_enable,
  output logic                        rx_enable,
  output logic                        baud_en,
  output logic      [1:0]             clk_exponent,
  output logic                        smart_card_select,
  output logic      [1:0]             ctrl_low_normal,
  output logic      [1:0]             ctrl_low_card,
  output sccs_pkg::sccs_irq_req_t     irq_req,
  output logic                        irq
);

  // ========================================================
  // Helper functions

  // Mask of low counter bits per prescaler exponent
  function automatic logic [5:0] div_mask(input logic [1:0] code);
    logic [5:0] m;
    m = `SCCS_DIV_MASK_0;
    case (code)
      2'h0: m = `SCCS_DIV_MASK_0;
      2'h1: m = `SCCS_DIV_MASK_1;
      2'h2: m = `SCCS_DIV_MASK_2;
      2'h3: m = `SCCS_DIV_MASK_3;
      default: m = `SCCS_DIV_MASK_0;
    endcase
    return m;
  endfunction

  // Flag update: hardware set beats a software clear
  function automatic logic flag_next(input logic cur,
                                     input logic hw_set,
                                     input logic sw_clr);
    logic v;
    v = cur;
    if (sw_clr) begin
      v = 1'b0;
    end
    if (hw_set) begin
      v = 1'b1;
    end
    return v;
  endfunction

  // ========================================================
  // State and decode
  sccs_pkg::sccs_state_t st;
  sccs_pkg::sccs_state_t next_st;

  logic       req_live;
  logic       wr;
  logic       rd;
  logic       lane0;
  logic [5:0] word;
  logic [7:0] wbyte;
  logic [4:0] hw_set;
  logic [4:0] sw_clr;
  logic [2:0] ev_set;
  logic [1:0] cks;
  logic       rx_ok;

  // A request is served once; ack drops the cycle after
  assign req_live = wb_cyc_i & wb_stb_i & ~st.ack;
  assign wr       = req_live & wb_we_i;
  assign rd       = req_live & ~wb_we_i;
  assign lane0    = wb_sel_i[0];
  assign word     = wb_adr_i[7:2];
  assign wbyte    = wb_dat_i[7:0];
  assign cks      = {st.mode[`SCCS_CKS_HI], st.mode[`SCCS_CKS_LO]};

  // Frames count only while the receiver is on
  assign rx_ok = st.ctrl[`SCCS_RE] & rx_ev.done; // RULE_10

  // ========================================================
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.ack   = req_live;
    next_st.rdata = `SCCS_RST_BYTE;

    // Hardware flag sets
    hw_set = '0;
    hw_set[`SCCS_TX_EMPTY_FLAG] = tx_taken;
    hw_set[`SCCS_RX_FULL_FLAG] = rx_ok;
    hw_set[`SCCS_OVERRUN_ERROR_FLAG] = rx_ok & rx_ev.overrun;
    hw_set[`SCCS_FER]  = rx_ok & rx_ev.framing;
    hw_set[`SCCS_PER]  = rx_ok & rx_ev.parity;

    // Clear by writing 0 only after a read that saw 1
    sw_clr = '0;
    if (wr && lane0 && word == `SCCS_OFS_STATUS) begin
      sw_clr = st.seen & ~wbyte[4:0]; // RULE_05 RULE_07
    end

    // Register writes
    if (wr && lane0) begin
      case (word)
        `SCCS_OFS_MODE:    next_st.mode   = wbyte;
        `SCCS_OFS_CTRL:    next_st.ctrl   = wbyte;
        `SCCS_OFS_TXDATA:  next_st.txdata = wbyte;
        `SCCS_OFS_CARD:    next_st.card   = wbyte[`SCCS_SMART_CARD_SELECT]; // RULE_11
        `SCCS_OFS_IRQ_MSK: next_st.mask   = wbyte[2:0];
        default: ;
      endcase
    end

    // Status flags, set wins
    for (int i = 0; i < 5; i++) begin
      next_st.status[i] = flag_next(st.status[i], hw_set[i], sw_clr[i]);
    end
    // Transmitter off pins the empty flag high
    if (!next_st.ctrl[`SCCS_TE]) begin
      next_st.status[`SCCS_TX_EMPTY_FLAG] = 1'b1; // RULE_09
    end

    // Read-seen memory: armed by a read, spent by a clear
    next_st.seen = st.seen & ~sw_clr & ~hw_set;
    if (rd && word == `SCCS_OFS_STATUS) begin
      next_st.seen = st.seen | st.status;
    end

    // Sticky events, write one to clear, set wins
    ev_set[`SCCS_EV_TX]  = tx_taken & st.ctrl[`SCCS_TE];
    ev_set[`SCCS_EV_RX]  = rx_ok;
    ev_set[`SCCS_EV_ERR] = hw_set[`SCCS_OVERRUN_ERROR_FLAG] | hw_set[`SCCS_FER] | hw_set[`SCCS_PER];
    for (int i = 0; i < 3; i++) begin
      next_st.ev[i] = flag_next(st.ev[i], ev_set[i],
        wr && lane0 && word == `SCCS_OFS_IRQ_ST && wbyte[i]);
    end

    // Read data
    if (rd) begin
      case (word)
        `SCCS_OFS_MODE:    next_st.rdata = st.mode;
        `SCCS_OFS_CTRL:    next_st.rdata = st.ctrl;
        `SCCS_OFS_STATUS:  next_st.rdata = {3'h0, st.status};
        `SCCS_OFS_TXDATA:  next_st.rdata = st.txdata;
        `SCCS_OFS_CARD:    next_st.rdata = {7'h00, st.card};
        `SCCS_OFS_IRQ_ST:  next_st.rdata = {5'h00, st.ev};
        `SCCS_OFS_IRQ_MSK: next_st.rdata = {5'h00, st.mask};
        default:           next_st.rdata = `SCCS_RST_BYTE;
      endcase
    end

    // Requests are plain AND of flags and enables
    next_st.req.tx  = next_st.ctrl[`SCCS_TIE] &
                      next_st.status[`SCCS_TX_EMPTY_FLAG]; // RULE_04 RULE_12
    next_st.req.rx  = next_st.ctrl[`SCCS_RIE] &
                      next_st.status[`SCCS_RX_FULL_FLAG]; // RULE_06 RULE_12
    next_st.req.err = next_st.ctrl[`SCCS_RIE] &
                      (next_st.status[`SCCS_OVERRUN_ERROR_FLAG] |
                       next_st.status[`SCCS_FER] |
                       next_st.status[`SCCS_PER]); // RULE_06 RULE_12
    next_st.irq = |(next_st.ev & next_st.mask);

    // Frame starts when enabled and data is pending
    next_st.tx_go = next_st.ctrl[`SCCS_TE] & ~next_st.status[`SCCS_TX_EMPTY_FLAG]; // RULE_08

    // Low control bits steered by mode, registered so the pins come from flops
    next_st.low_normal = next_st.card ? 2'h0 : next_st.ctrl[1:0]; // RULE_03
    next_st.low_card   = next_st.card ? next_st.ctrl[1:0] : 2'h0; // RULE_03

    // Prescaler for the baud generator input
    next_st.div_cnt = st.div_cnt + 6'h01;
    next_st.baud_en = (st.div_cnt & div_mask(cks)) == div_mask(cks); // RULE_01
  end

  // ========================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st        <= '0;
      st.status <= `SCCS_RST_STATUS;
      st.ev     <= `SCCS_RST_EV;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================
  // Outputs, all straight from the state register
  assign wb_ack_o          = st.ack;
  assign wb_dat_o          = {24'h000000, st.rdata};
  assign tx_go             = st.tx_go;
  assign tx_data           = st.txdata;
  assign tx_enable         = st.ctrl[`SCCS_TE];
  assign rx_enable         = st.ctrl[`SCCS_RE];
  assign baud_en           = st.baud_en;
  assign clk_exponent      = cks; // RULE_02
  assign smart_card_select = st.card;
  // Mode views of the low control bits; the idle view reads 0
  assign ctrl_low_normal   = st.low_normal; // RULE_03
  assign ctrl_low_card     = st.low_card; // RULE_03
  assign irq_req           = st.req;
  assign irq               = st.irq;

endmodule

// >>> sccs_ctrl_chk.sv
`timescale 1ns/10ps
module sccs_ctrl_chk (
  input wire logic                    sys_clk,
  input wire logic                    reset,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic                    wb_ack_o,
  input wire logic                    tx_taken,
  input wire logic                    tx_go,
  input wire logic                    tx_enable,
  input wire logic                    baud_en,
  input wire logic [1:0]              clk_exponent,
  input wire logic                    smart_card_select,
  input wire logic [1:0]              ctrl_low_normal,
  input wire logic [1:0]              ctrl_low_card,
  input wire sccs_pkg::sccs_irq_req_t irq_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Divider steps
  sequence s_quarter_gap;
    (baud_en && clk_exponent == 2'h1) ##1 (!baud_en && clk_exponent == 2'h1) [*3];
  endsequence
  sequence s_full_hold;
    (clk_exponent == 2'h0) [*4];
  endsequence
  // Bus answer is one pulse per request
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  // Exponent only moves by a register write; baud_en keeps the step of exponents 0 and 1
  a_exp_by_write: assert property ($changed(clk_exponent) |-> wb_ack_o && wb_we_i)
    else $error("exponent moved alone");
  a_quarter_rate: assert property (s_quarter_gap |=> baud_en)
    else $error("quarter rate wrong");
  a_full_rate: assert property (s_full_hold |-> baud_en)
    else $error("full rate wrong");
  // Transmit start needs enable, pending data and empty request exclude each other, mode views split
  a_go_needs_en: assert property (tx_go |-> tx_enable)
    else $error("go while disabled");
  a_req_not_go: assert property (irq_req.tx |-> !tx_go)
    else $error("tx request with data");
  a_taken_drops: assert property (tx_taken |=> !tx_go)
    else $error("go after taken");
  a_card_split: assert property (smart_card_select ? ctrl_low_normal == 2'h0
    : ctrl_low_card == 2'h0) else $error("mode view wrong");
endmodule
bind sccs_ctrl sccs_ctrl_chk chk_u (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .tx_taken(tx_taken),
  .tx_go(tx_go), .tx_enable(tx_enable), .baud_en(baud_en), .clk_exponent(clk_exponent),
  .smart_card_select(smart_card_select), .ctrl_low_normal(ctrl_low_normal),
  .ctrl_low_card(ctrl_low_card), .irq_req(irq_req));

// >>> tb_sccs_ctrl.sv
`timescale 1ns/10ps
module tb_sccs_ctrl;
  logic                    sys_clk = 1'b0;
  logic                    reset = 1'b1;
  logic                    wb_cyc_i = 1'b0;
  logic                    wb_stb_i = 1'b0;
  logic                    wb_we_i = 1'b0;
  logic                    tx_taken = 1'b0;
  logic [7:0]              wb_adr_i = 8'h00;
  logic [31:0]             wb_dat_i = 32'h0;
  logic [31:0]             wb_dat_o;
  logic                    wb_ack_o, tx_go, tx_enable, rx_enable, baud_en, card, irq;
  logic [7:0]              tx_data, rd;
  logic [1:0]              clk_exponent, low_n, low_c;
  sccs_pkg::sccs_rx_ev_t   rx_ev = 4'h0;
  sccs_pkg::sccs_irq_req_t irq_req;
  int                      errors = 0, n_compared = 0, cycles = 0, i, k;
  always #20 sys_clk = ~sys_clk;
  // Write strobe tied: only byte lane 0 exists
  sccs_ctrl dut_u (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_taken(tx_taken), .rx_ev(rx_ev),
    .tx_go(tx_go), .tx_data(tx_data), .tx_enable(tx_enable), .rx_enable(rx_enable),
    .baud_en(baud_en), .clk_exponent(clk_exponent), .smart_card_select(card),
    .ctrl_low_normal(low_n), .ctrl_low_card(low_c), .irq_req(irq_req), .irq(irq));
  task automatic test_done;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One classic cycle; the wait ends only on ack or the timeout
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  // One-cycle event pulse, then an edge for it to land
  task automatic pulse(input logic t, input logic [3:0] e);
    @(posedge sys_clk);
    tx_taken <= t;
    rx_ev <= e;
    @(posedge sys_clk);
    tx_taken <= 1'b0;
    rx_ev <= 4'h0;
    @(posedge sys_clk);
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(8'h04, 8'h00);
    rdc(8'h08, 8'h10);
    rdc(8'h3c, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      wr(8'h00, i[7:0]);
      chk({6'h0, clk_exponent}, i[7:0]);
      k = 0;
      repeat (64) begin
        @(posedge sys_clk);
        k += baud_en;
      end
      chk(k[7:0], 8'h40 >> (2 * i));
    end
    $display("test prescaler done");
    wr(8'h04, 8'h80);
    chk({5'h0, irq_req}, 8'h01);
    // Spend the read armed at reset; the clear is void while transmit is off
    wr(8'h08, 8'h00);
    chk({5'h0, irq_req}, 8'h01);
    wr(8'h04, 8'ha0);
    wr(8'h0c, 8'h5a);
    chk(tx_data, 8'h5a);
    // Clear without a prior read must not count
    wr(8'h08, 8'h00);
    chk({7'h0, tx_go}, 8'h00);
    rdc(8'h08, 8'h10);
    wr(8'h08, 8'h00);
    chk({4'h0, tx_go, irq_req}, 8'h08);
    pulse(1'b1, 4'h0);
    chk({6'h0, tx_go, irq}, 8'h00);
    wr(8'h18, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr(8'h14, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wr(8'h04, 8'h20);
    chk({5'h0, irq_req}, 8'h00);
    rdc(8'h08, 8'h10);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h00);
    chk({7'h0, tx_go}, 8'h00);
    rdc(8'h08, 8'h10);
    $display("test transmit done");
    wr(8'h04, 8'h50);
    chk({6'h0, rx_enable, tx_enable}, 8'h02);
    pulse(1'b0, 4'h9);
    chk({5'h0, irq_req}, 8'h06);
    rdc(8'h14, 8'h06);
    rdc(8'h08, 8'h19);
    wr(8'h08, 8'h10);
    chk({5'h0, irq_req}, 8'h00);
    pulse(1'b0, 4'h8);
    wr(8'h04, 8'h10);
    chk({5'h0, irq_req}, 8'h00);
    rdc(8'h08, 8'h18);
    wr(8'h08, 8'h10);
    wr(8'h04, 8'h40);
    pulse(1'b0, 4'h8);
    chk({5'h0, irq_req}, 8'h00);
    $display("test receive done");
    wr(8'h04, 8'h03);
    wr(8'h10, 8'h01);
    chk({3'h0, card, low_n, low_c}, 8'h13);
    wr(8'h10, 8'h00);
    chk({3'h0, card, low_n, low_c}, 8'h0c);
    $display("test card done");
    test_done;
  end
endmodule
